// [verilog/dvo_debug_map.vh]
// Address map, field positions, reset values and timing figures of the debug register space.
// Assumes the includer works on byte offsets inside the 4096-byte memory window.
`ifndef DVO_DEBUG_MAP_VH
`define DVO_DEBUG_MAP_VH

// Window and region layout, byte offsets inside the memory window.
`define DVO_WIN_AW 12
`define DVO_DEBUG_HALF_BIT 11
`define DVO_REGION_AW 7
`define DVO_VENDOR_TAG 5'h10
`define DVO_DIRECT_TAG 5'h11
`define DVO_PKT_CTRL_OFS 12'h800
`define DVO_VENDOR_WORDS 32
`define DVO_WORD_IDX_W 5

// Packet option control fields.
`define DVO_PKT_EXT_TICK_SEL 23
`define DVO_PKT_CHECK_PHY 9
`define DVO_PKT_BUS_RESET_PKT 8
`define DVO_PKT_CONCAT 7
`define DVO_PKT_AUTO_EXT 4
`define DVO_PKT_AUTO_PING 2
`define DVO_PKT_AUTO_LINK 1
`define DVO_PKT_AUTO_PHY 0
`define DVO_PKT_RESET 32'h00000114
`define DVO_PKT_IMPL_MASK 32'h00800397

// PHY register fields written by a configuration packet.
`define DVO_GAP_W 6
`define DVO_GAP_RESET 6'h3F

// Cycle tick timing: 8 kHz period and system clock period, both in ns.
`define DVO_TICK_PERIOD_NS 125000
`define DVO_SYS_CLK_NS 40
`define DVO_TICK_CYCLES (`DVO_TICK_PERIOD_NS / `DVO_SYS_CLK_NS)
`define DVO_TICK_CNT_W 16

`endif

// [verilog/dvo_debug_regs.v]
// Debug register space decoder with the vendor option registers and packet option control.
// Assumes the host target logic has already decoded a hit on the 4096-byte memory window and
// hands over single-cycle read or write strobes; link-side event pulses share sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "dvo_debug_map.vh"

module dvo_debug_regs #(
  parameter TICK_CYCLES = `DVO_TICK_CYCLES
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Memory window access from the host target.
  input wire memRead,
  input wire memWrite,
  input wire [`DVO_WIN_AW-1:2] memAddr,
  input wire [3:0] memByteEn,
  input wire [31:0] memWdata,
  output reg [31:0] memRdata,
  output reg memAck,
  output reg debugHit,
  // Configuration EEPROM loader.
  input wire eepromLoadDone,
  input wire eepromDebugMode,
  // Link layer controls and events.
  input wire link_layer_enable,
  input wire linkOnPktRx,
  input wire phyConfigPktRx,
  input wire [`DVO_GAP_W-1:0] phyConfigGapCount,
  input wire phyConfigRootHold,
  input wire pingPktRx,
  input wire external_cycle_source,
  input wire external_cycle_clock_in,
  // Results towards the link and PHY.
  output reg linkPacketEnable,
  output reg [`DVO_GAP_W-1:0] phyGapCount,
  output reg root_hold_bit,
  output reg phyRegUpdated,
  output reg selfIdTxReq,
  output reg cycleTick,
  output reg checkPhyInverse,
  output reg busResetPktEnable,
  output reg concatEnable,
  output reg autoExtReply,
  output reg debugEnable
);

  // The last count is cut to the counter width on purpose; the divider never exceeds it.
  localparam integer TICK_LAST_FULL = TICK_CYCLES - 1;
  localparam [`DVO_TICK_CNT_W-1:0] TICK_LAST = TICK_LAST_FULL[`DVO_TICK_CNT_W-1:0];

  wire [`DVO_WIN_AW-1:0] byteAddr;
  wire inDebugHalf;
  wire inVendor;
  wire inDirect;
  wire [`DVO_WORD_IDX_W-1:0] wordIdx;
  wire isPktCtrl;
  wire [31:0] byteMask;
  wire wrOk;
  wire rdOk;

  reg [31:0] packet_option_control;
  reg [31:0] vendorWord [1:`DVO_VENDOR_WORDS-1];
  reg [31:0] next_packetCtrl;
  reg linkOnSeen;
  reg extSync1;
  reg extSync2;
  reg extSync3;
  reg extLevel;
  reg [`DVO_TICK_CNT_W-1:0] tickCount;
  reg internalTick;
  reg externalTick;
  integer i;

  assign byteAddr = {memAddr, 2'b00};
  assign inDebugHalf = byteAddr[`DVO_DEBUG_HALF_BIT];
  assign inVendor = byteAddr[`DVO_WIN_AW-1:`DVO_REGION_AW] == `DVO_VENDOR_TAG;
  assign inDirect = byteAddr[`DVO_WIN_AW-1:`DVO_REGION_AW] == `DVO_DIRECT_TAG;
  assign wordIdx = byteAddr[`DVO_REGION_AW-1:2];
  assign isPktCtrl = byteAddr == `DVO_PKT_CTRL_OFS;
  assign byteMask = {{8{memByteEn[3]}}, {8{memByteEn[2]}}, {8{memByteEn[1]}}, {8{memByteEn[0]}}};
  // Access is gated by the strap copied from the EEPROM.
  assign wrOk = memWrite && inVendor && debugEnable;
  assign rdOk = memRead && inDebugHalf && debugEnable;

  // The debug strap is caught when the EEPROM loader finishes, never at reset itself.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      debugEnable <= 1'b0;
    end else if (eepromLoadDone) begin
      debugEnable <= eepromDebugMode;
    end
  end

  // Only implemented bits take the written value; the rest of the word stays zero.
  always @* begin
    next_packetCtrl = packet_option_control;
    if (wrOk && isPktCtrl) begin
      next_packetCtrl = ((memWdata & byteMask) | (packet_option_control & ~byteMask))
        & `DVO_PKT_IMPL_MASK;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      packet_option_control <= `DVO_PKT_RESET;
    end else begin
      packet_option_control <= next_packetCtrl;
    end
  end

  // Remaining vendor option words are plain storage with byte enables.
  always @(posedge sys_clk) begin
    if (wrOk && !isPktCtrl) begin
      for (i = 1; i < `DVO_VENDOR_WORDS; i = i + 1) begin
        if (wordIdx == i[`DVO_WORD_IDX_W-1:0]) begin
          vendorWord[i] <= (memWdata & byteMask) | (vendorWord[i] & ~byteMask);
        end
      end
    end
  end

  // Read port: answers every strobe one cycle later, zero when the space is closed.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      memRdata <= 32'h00000000;
      memAck <= 1'b0;
      debugHit <= 1'b0;
    end else begin
      memAck <= memRead || memWrite;
      debugHit <= (memRead || memWrite) && inDebugHalf;
      if (!rdOk) begin
        memRdata <= 32'h00000000;
      end else if (inDirect || !inVendor) begin
        // The direct transfer region and the rest of the upper half read as zero.
        memRdata <= 32'h00000000;
      end else if (isPktCtrl) begin
        memRdata <= packet_option_control;
      end else begin
        memRdata <= vendorWord[wordIdx];
      end
    end
  end

  // Static mode outputs mirror the control word so that every port leaves a flop.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      checkPhyInverse <= 1'b0;
      busResetPktEnable <= 1'b0;
      concatEnable <= 1'b0;
      autoExtReply <= 1'b0;
    end else begin
      checkPhyInverse <= packet_option_control[`DVO_PKT_CHECK_PHY];
      busResetPktEnable <= packet_option_control[`DVO_PKT_BUS_RESET_PKT];
      concatEnable <= packet_option_control[`DVO_PKT_CONCAT];
      autoExtReply <= packet_option_control[`DVO_PKT_AUTO_EXT];
    end
  end

  // A link-on arriving while the link is being disabled still counts; the set wins.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      linkOnSeen <= 1'b0;
    end else if (linkOnPktRx) begin
      linkOnSeen <= 1'b1;
    end else if (!link_layer_enable) begin
      linkOnSeen <= 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      linkPacketEnable <= 1'b0;
    end else begin
      linkPacketEnable <= link_layer_enable
        && (!packet_option_control[`DVO_PKT_AUTO_LINK] || linkOnSeen);
    end
  end

  // PHY configuration packets rewrite gap count and root hold only in auto mode.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phyGapCount <= `DVO_GAP_RESET;
      root_hold_bit <= 1'b0;
      phyRegUpdated <= 1'b0;
    end else begin
      phyRegUpdated <= 1'b0;
      if (phyConfigPktRx && packet_option_control[`DVO_PKT_AUTO_PHY]) begin
        phyGapCount <= phyConfigGapCount;
        root_hold_bit <= phyConfigRootHold;
        phyRegUpdated <= 1'b1;
      end
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      selfIdTxReq <= 1'b0;
    end else begin
      selfIdTxReq <= pingPktRx && packet_option_control[`DVO_PKT_AUTO_PING];
    end
  end

  // The external 8 kHz clock is asynchronous; a level is accepted once stages two and three agree.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extSync3 <= 1'b0;
      extLevel <= 1'b0;
      externalTick <= 1'b0;
    end else begin
      extSync1 <= external_cycle_clock_in;
      extSync2 <= extSync1;
      extSync3 <= extSync2;
      externalTick <= 1'b0;
      if (extSync2 == extSync3 && extSync3 != extLevel) begin
        extLevel <= extSync3;
        externalTick <= extSync3;
      end
    end
  end

  // The derived tick divides sys_clk; the remainder against a true 24.576 MHz source is accepted.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCount <= {`DVO_TICK_CNT_W{1'b0}};
      internalTick <= 1'b0;
    end else if (tickCount == TICK_LAST) begin
      tickCount <= {`DVO_TICK_CNT_W{1'b0}};
      internalTick <= 1'b1;
    end else begin
      tickCount <= tickCount + 1'b1;
      internalTick <= 1'b0;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycleTick <= 1'b0;
    end else if (external_cycle_source && packet_option_control[`DVO_PKT_EXT_TICK_SEL]) begin
      cycleTick <= externalTick;
    end else begin
      cycleTick <= internalTick;
    end
  end

endmodule // dvo_debug_regs
`default_nettype wire

// [sim/dvo_debug_regs_assertions.sv]
// Port checks for the debug register block.
// Assumes a bind into dvo_debug_regs, one sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module dvo_debug_regs_assertions (
  // Clock, reset and register port.
  input wire sys_clk,
  input wire rst_n,
  input wire memRead,
  input wire memWrite,
  input wire [11:2] memAddr,
  input wire [31:0] memRdata,
  input wire memAck,
  input wire debugHit,
  input wire debugEnable,
  // Link events and results.
  input wire phyConfigPktRx,
  input wire [5:0] phyConfigGapCount,
  input wire [5:0] phyGapCount,
  input wire phyRegUpdated,
  input wire pingPktRx,
  input wire selfIdTxReq,
  input wire link_layer_enable,
  input wire linkPacketEnable,
  input wire cycleTick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence sReq; memRead || memWrite; endsequence
  sequence sBlind; memRead && (!debugEnable || memAddr[11:7] != 5'h10); endsequence
  sequence sPhy; phyConfigPktRx ##1 phyRegUpdated; endsequence
  a_ack_follows_req: assert property (sReq |=> memAck) else $error("no ack");
  a_ack_has_cause: assert property (memAck |-> $past(memRead || memWrite))
    else $error("stray ack");
  a_hit_upper_half: assert property (memAck |-> debugHit == $past(memAddr[11]))
    else $error("bad hit");
  a_blind_read_zero: assert property (sBlind |=> memRdata == 32'h0)
    else $error("read not zero");
  a_phy_load_value: assert property (sPhy |->
    phyGapCount == $past(phyConfigGapCount)) else $error("bad gap");
  a_phy_update_cause: assert property (phyRegUpdated |-> $past(phyConfigPktRx))
    else $error("stray update");
  a_gap_hold_stable: assert property (!phyRegUpdated |-> $stable(phyGapCount))
    else $error("gap moved");
  a_ping_reply_cause: assert property (selfIdTxReq |-> $past(pingPktRx))
    else $error("stray reply");
  a_link_needs_enable: assert property (!link_layer_enable |=> !linkPacketEnable)
    else $error("link open");
  a_tick_single_pulse: assert property (cycleTick |=> !cycleTick)
    else $error("long tick");
endmodule // dvo_debug_regs_assertions
bind dvo_debug_regs dvo_debug_regs_assertions u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .memRead(memRead), .memWrite(memWrite), .memAddr(memAddr), .memRdata(memRdata),
  .memAck(memAck), .debugHit(debugHit), .debugEnable(debugEnable),
  .phyConfigPktRx(phyConfigPktRx), .phyConfigGapCount(phyConfigGapCount),
  .phyGapCount(phyGapCount), .phyRegUpdated(phyRegUpdated), .pingPktRx(pingPktRx),
  .selfIdTxReq(selfIdTxReq), .link_layer_enable(link_layer_enable),
  .linkPacketEnable(linkPacketEnable), .cycleTick(cycleTick));
`default_nettype wire

// [sim/dvo_eeprom_model.sv]
// Configuration memory loader model that hands over the debug enable bit.
// Assumes the bench asks for a load with a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
module dvo_eeprom_model (
  // Clock and load request.
  input wire sys_clk,
  input wire loadReq,
  input wire debugBit,
  // Loader outputs.
  output reg eepromLoadDone = 1'b0,
  output wire eepromDebugMode
);
  always @(posedge sys_clk) eepromLoadDone <= loadReq;
  // Outside the load pulse the bit is not held, so show its inverse.
  assign eepromDebugMode = eepromLoadDone ? debugBit : ~debugBit;
endmodule // dvo_eeprom_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the debug register block.
// Assumes the loader model opens or closes the debug space on request.
`timescale 1ns/1ps
`default_nettype none
module tb;
  reg sysClk = 1'b0, rstN = 1'b0, memRead = 1'b0, memWrite = 1'b0, loadReq = 1'b0, dbgBit = 1'b0;
  reg linkEn = 1'b0, linkOn = 1'b0, phyCfg = 1'b0, hold = 1'b0, ping = 1'b0, extSrc = 1'b0;
  reg extClk = 1'b0;
  reg [9:0] memAddr = 10'h0;
  reg [3:0] memByteEn = 4'h0, be;
  reg [5:0] gap = 6'h0, gapExp = 6'h3F;
  reg rootExp = 1'b0;
  reg [31:0] memWdata = 32'h0, rd, d, ctrl = 32'h00000114, seed = 32'h3F8818A9;
  wire [31:0] memRdata;
  wire [5:0] phyGap;
  wire memAck, hit, done, mode, linkPkt, rootHold, upd, selfId, tick, inv, brp, cat, ext, dbgEn;
  integer fails = 0, checked = 0, ticks = 0, i, t;
  always #20 sysClk = ~sysClk;
  always @(posedge sysClk) if (tick) ticks <= ticks + 1;
  dvo_eeprom_model EEP (.sys_clk(sysClk), .loadReq(loadReq), .debugBit(dbgBit),
    .eepromLoadDone(done), .eepromDebugMode(mode));
  dvo_debug_regs #(.TICK_CYCLES(8)) DUT (.sys_clk(sysClk), .rst_n(rstN), .memRead(memRead),
    .memWrite(memWrite), .memAddr(memAddr), .memByteEn(memByteEn), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .debugHit(hit), .eepromLoadDone(done),
    .eepromDebugMode(mode), .link_layer_enable(linkEn), .linkOnPktRx(linkOn),
    .phyConfigPktRx(phyCfg), .phyConfigGapCount(gap), .phyConfigRootHold(hold),
    .pingPktRx(ping), .external_cycle_source(extSrc), .external_cycle_clock_in(extClk),
    .linkPacketEnable(linkPkt), .phyGapCount(phyGap), .root_hold_bit(rootHold),
    .phyRegUpdated(upd), .selfIdTxReq(selfId), .cycleTick(tick), .checkPhyInverse(inv),
    .busResetPktEnable(brp), .concatEnable(cat), .autoExtReply(ext), .debugEnable(dbgEn));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Only implemented control bits survive a byte-lane merge.
  function [31:0] merge(input [31:0] o, input [31:0] w, input [3:0] b);
    merge = ((o & ~{{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}}) |
      (w & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}})) & 32'h00800397;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task acc(input wr, input [11:0] a, input [31:0] w, input [3:0] b);
    begin
      @(posedge sysClk);
      memRead <= ~wr;
      memWrite <= wr;
      memAddr <= a[11:2];
      memWdata <= w;
      memByteEn <= b;
      @(posedge sysClk);
      memRead <= 1'b0;
      memWrite <= 1'b0;
      #1 rd = memRdata;
      chk(memAck, 1'b1);
      chk(hit, a[11]);
    end
  endtask
  task ev(input [2:0] m, input [6:0] g);
    begin
      @(posedge sysClk);
      {linkOn, phyCfg, ping} <= m;
      {hold, gap} <= g;
      @(posedge sysClk);
      {linkOn, phyCfg, ping} <= 3'h0;
      #1;
    end
  endtask
  task load(input b);
    begin
      @(posedge sysClk);
      dbgBit <= b;
      loadReq <= 1'b1;
      @(posedge sysClk);
      loadReq <= 1'b0;
      repeat (3) @(posedge sysClk);
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #400000;
    fails = fails + 1;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge sysClk);
    rstN <= 1'b1;
    acc(1'b1, 12'h800, 32'hFFFFFFFF, 4'hF);
    acc(1'b0, 12'h800, 32'h0, 4'h0);
    chk(rd, 32'h0);
    load(1'b1);
    #1 chk(dbgEn, 1'b1);
    acc(1'b0, 12'h800, 32'h0, 4'h0);
    chk(rd, ctrl);
    acc(1'b0, 12'h880, 32'h0, 4'h0);
    chk(rd, 32'h0);
    acc(1'b1, 12'h844, 32'h12345678, 4'hF);
    acc(1'b1, 12'h844, 32'hA5A5A5A5, 4'h6);
    acc(1'b0, 12'h844, 32'h0, 4'h0);
    chk(rd, 32'h12A5A578);
    acc(1'b1, 12'h400, 32'hFFFFFFFF, 4'hF);
    acc(1'b0, 12'h400, 32'h0, 4'h0);
    chk(rd, 32'h0);
    $display("access tests ended");
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      d = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFFFFFF : seed;
      be = (i < 2) ? 4'hF : seed[27:24];
      acc(1'b1, 12'h800, d, be);
      ctrl = merge(ctrl, d, be);
      acc(1'b0, 12'h800, 32'h0, 4'h0);
      chk(rd, ctrl);
      chk({inv, brp, cat, ext}, {ctrl[9], ctrl[8], ctrl[7], ctrl[4]});
      ev(3'b001, 7'h0);
      chk(selfId, ctrl[2]);
      ev(3'b010, seed[6:0]);
      if (ctrl[0]) begin
        gapExp = seed[5:0];
        rootExp = seed[6];
      end
      chk({upd, rootHold, phyGap}, {ctrl[0], rootExp, gapExp});
    end
    $display("control tests ended");
    acc(1'b1, 12'h800, 32'h0, 4'hF);
    @(posedge sysClk) linkEn <= 1'b1;
    repeat (2) @(posedge sysClk);
    #1 chk(linkPkt, 1'b1);
    acc(1'b1, 12'h800, 32'h2, 4'hF);
    repeat (4) @(posedge sysClk);
    #1 chk(linkPkt, 1'b0);
    ev(3'b100, 7'h0);
    @(posedge sysClk);
    #1 chk(linkPkt, 1'b1);
    $display("link tests ended");
    @(posedge sysClk) extSrc <= 1'b1;
    acc(1'b1, 12'h800, 32'h0, 4'hF);
    t = ticks;
    repeat (64) @(posedge sysClk);
    #1 chk(ticks - t, 8);
    acc(1'b1, 12'h800, 32'h00800000, 4'hF);
    repeat (16) @(posedge sysClk);
    t = ticks;
    repeat (32) @(posedge sysClk);
    #1 chk(ticks - t, 0);
    @(posedge sysClk) extClk <= 1'b1;
    repeat (10) @(posedge sysClk);
    #1 chk(ticks - t, 1);
    load(1'b0);
    #1 chk(dbgEn, 1'b0);
    acc(1'b1, 12'h800, 32'hFFFFFFFF, 4'hF);
    acc(1'b0, 12'h800, 32'h0, 4'h0);
    chk(rd, 32'h0);
    load(1'b1);
    acc(1'b0, 12'h800, 32'h0, 4'h0);
    chk(rd, 32'h00800000);
    $display("tick and closing tests ended");
    complete_run;
  end
endmodule // tb
`default_nettype wire
